// ==== burn_timer.sv ====
/*
 * Fixed-length timer for one fuse programming operation; done marks the
 * last busy cycle, so a registered follower can drop together with busy.
 * Assumes start is a one-cycle pulse on the same clock, ignored while busy.
 */
`timescale 1ns/1ps
module burn_timer #(
	parameter int CYCLES = 4000000
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	localparam int CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
	localparam logic [CNT_W-1:0] PRE_LAST = CNT_W'(CYCLES - 2);

	logic [CNT_W-1:0] count_r;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_r <= '0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in && !busy_out) begin
				busy_out <= 1'b1;
				count_r <= '0;
				done_out <= (CYCLES == 1);
			end else if (busy_out) begin
				if (count_r == LAST) begin
					busy_out <= 1'b0;
				end else begin
					count_r <= count_r + 1'b1;
					done_out <= (count_r == PRE_LAST);
				end
			end
		end
	end
endmodule : burn_timer

// ==== host_model.sv ====
/* Host on the register port: single writes, reads and the keyed burn order.
   Assumes accesses are taken on the rising edge while the strobe is high. */
`timescale 1ns/1ps
module host_model
	import nvm_cfg_pkg::*;
(
	input wire logic mclk_in,
	input wire logic [nvm_cfg_pkg::DATA_W-1:0] reg_rdata_in,
	output logic [nvm_cfg_pkg::ADDR_W-1:0] reg_addr_out,
	output logic [nvm_cfg_pkg::DATA_W-1:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	// Released lines show the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		#1;
		reg_addr_out = a;
		reg_wdata_out = v;
		reg_wr_out = 1'b1;
		@(posedge mclk_in);
		#1;
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~v;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk_in);
		#1;
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(posedge mclk_in);
		#1;
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		v = reg_rdata_in;
	endtask : rd
	// Caller keeps the motor stopped first and reads back afterwards
	task automatic prog(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
		wr(ADDR_PROG_CTRL, 8'h04);
		wr(ADDR_RES_LOW, r0);
		wr(ADDR_RES_BEMF_HIGH, r1);
		wr(ADDR_BEMF_LOW, r2);
		wr(ADDR_UNLOCK_KEY, UNLOCK_KEY_VALUE);
		wr(ADDR_PROG_CTRL, 8'h05);
	endtask : prog
endmodule : host_model

// ==== nvm_cfg_pkg.sv ====
/*
 * Shared constants for the fuse-backed configuration and power-mode logic:
 * register offsets, field positions, reset values, key and timing counts.
 * Assumes the register port carries 8-bit addresses and 8-bit data.
 */
package nvm_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] ADDR_SPEED_MSB = 8'h01;
	localparam logic [7:0] ADDR_SPEED_LSB = 8'h02;
	localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h18;
	localparam logic [7:0] ADDR_PROG_CTRL = 8'h19;
	localparam logic [7:0] ADDR_POWER_STATUS = 8'h1A;
	localparam logic [7:0] ADDR_RES_LOW = 8'h20;
	localparam logic [7:0] ADDR_RES_BEMF_HIGH = 8'h21;
	localparam logic [7:0] ADDR_BEMF_LOW = 8'h22;
	localparam logic [7:0] ADDR_POWER_CFG = 8'h2C;

	localparam int PROG_START_BIT = 0;
	localparam int LATCH_EN_BIT = 2;
	localparam int SLEEP_SEL_BIT = 2;
	localparam int STAT_STANDBY_BIT = 0;
	localparam int STAT_SLEEP_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hCA;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] DUTY_FULL = 8'hFF;

	// Scaling of the motor codes, per count
	localparam int RES_LSB_MOHM = 10;
	localparam int BEMF_LSB_MV_PER_HZ = 1;

	localparam int CLK_FREQ_MHZ = 200;
	localparam int BURN_TIME_US = 20000;
	localparam int BURN_CYCLES = BURN_TIME_US * CLK_FREQ_MHZ;

	// Image burned to and loaded from the fuse macro, one byte per register
	localparam int IMG_W = 32;

	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_STANDBY,
		PWR_SLEEP
	} power_state_t;
endpackage : nvm_cfg_pkg

// ==== nvm_power_ctrl.sv ====
/*
 * Configuration registers, fuse load and burn sequencing, and the
 * sleep / standby power state of a sensorless motor driver.
 * Assumes the serial core delivers register accesses on the plain port
 * below, and a fuse macro whose stored image is always readable.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Function
// (RULE1) Sleep-select 0: zero speed on pin or serial command enters standby.
// (RULE2) Sleep-select 1: zero speed on the pin enters sleep.
// (RULE3) Serial interface off in sleep; only the speed pin wakes the device.
// (RULE4) Serial access keeps working in standby; hosts should prefer standby.
// (RULE5) Motor outputs stop in sleep and standby.
// (RULE6) Fuse image copied into registers at power-on and every sleep exit.
// (RULE7) Host sets latch enable, then writes motor parameters.
// (RULE8) Host writes unlock key before starting programming.
// (RULE9) Program start with latch enable held burns registers into fuses.
// (RULE10) Programming lasts about twenty milliseconds.
// (RULE11) Program-start bit clears itself when burning finishes.
// (RULE12) Host programs with motor stopped, power-cycles, reads back.
// (RULE13) Resistance code twelve bits: low byte, upper nibble next address.
// (RULE14) Resistance code counts ten milliohms per step, linear.
// (RULE15) BEMF code twelve bits: upper nibble shared, low byte next address.
// (RULE16) BEMF code counts one millivolt per hertz per step, up to 4095.
// (RULE17) PWM duty sets output amplitude proportionally; full duty full amplitude.
// (RULE18) Host register writes override the fuse-loaded configuration.
// (RULE19) Serial speed command held as MSB then LSB register.
// (RULE20) Start ignored without correct key; key cleared after each attempt.
module nvm_power_ctrl
	import nvm_cfg_pkg::*;
#(
	parameter int BURN_CYCLE_COUNT = BURN_CYCLES
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic speed_pin_zero_in,
	input wire logic [nvm_cfg_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [nvm_cfg_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [nvm_cfg_pkg::IMG_W-1:0] nvm_rdata_in,
	output logic [nvm_cfg_pkg::DATA_W-1:0] reg_rdata_out,
	output logic serial_enable_out,
	output logic motor_drive_enable_out,
	output logic pwm_out,
	output logic [11:0] phase_resistance_code_out,
	output logic [11:0] bemf_constant_code_out,
	output logic [nvm_cfg_pkg::IMG_W-1:0] nvm_wdata_out,
	output logic nvm_burn_out
);
	import nvm_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser

	logic pin_meta_r;
	logic pin_zero_r;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_meta_r <= 1'b1;
			pin_zero_r <= 1'b1;
		end else begin
			pin_meta_r <= speed_pin_zero_in;
			pin_zero_r <= pin_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register storage

	power_state_t state_r;
	power_state_t state_nxt;
	logic [7:0] speed_msb_r;
	logic [7:0] speed_lsb_r;
	logic [7:0] key_r;
	logic latch_en_r;
	logic prog_start_r;
	logic [7:0] res_low_r;
	logic [7:0] res_bemf_high_r;
	logic [7:0] bemf_low_r;
	logic [7:0] power_cfg_r;
	logic load_pending_r;
	logic burn_busy;
	logic burn_done;
	logic burn_start;
	logic wr_ok;
	logic sleep_exit;
	logic cmd_zero;

	// Serial core is switched off in sleep, so nothing is taken there
	assign wr_ok = reg_wr_in && (state_r != PWR_SLEEP); // RULE3
	assign sleep_exit = (state_r == PWR_SLEEP) && (state_nxt != PWR_SLEEP);
	assign cmd_zero = ({speed_msb_r, speed_lsb_r} == 16'h0000);

	// Accepted only with key, latch enable and idle engine
	assign burn_start = wr_ok && (reg_addr_in == ADDR_PROG_CTRL)
		&& reg_wdata_in[PROG_START_BIT] && reg_wdata_in[LATCH_EN_BIT]
		&& (key_r == UNLOCK_KEY_VALUE) && !burn_busy; // RULE9 RULE20

	// Load stays pending from reset until the first edge after release
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			load_pending_r <= 1'b1;
		end else begin
			load_pending_r <= sleep_exit; // RULE6
		end
	end

	// Fuse image loads first; later host writes take over
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			res_low_r <= REG_RESET;
			res_bemf_high_r <= REG_RESET;
			bemf_low_r <= REG_RESET;
			power_cfg_r <= REG_RESET;
		end else if (load_pending_r) begin
			res_low_r <= nvm_rdata_in[7:0]; // RULE6
			res_bemf_high_r <= nvm_rdata_in[15:8];
			bemf_low_r <= nvm_rdata_in[23:16];
			power_cfg_r <= nvm_rdata_in[31:24];
		end else if (wr_ok) begin
			case (reg_addr_in) // RULE18
				ADDR_RES_LOW: begin
					res_low_r <= reg_wdata_in;
				end
				ADDR_RES_BEMF_HIGH: begin
					res_bemf_high_r <= reg_wdata_in;
				end
				ADDR_BEMF_LOW: begin
					bemf_low_r <= reg_wdata_in;
				end
				ADDR_POWER_CFG: begin
					power_cfg_r <= reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			speed_msb_r <= REG_RESET;
			speed_lsb_r <= REG_RESET;
		end else if (wr_ok) begin
			if (reg_addr_in == ADDR_SPEED_MSB) begin
				speed_msb_r <= reg_wdata_in; // RULE19
			end
			if (reg_addr_in == ADDR_SPEED_LSB) begin
				speed_lsb_r <= reg_wdata_in; // RULE19
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fuse programming

	// Any start request uses up the key, so a retry needs a fresh key
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			key_r <= REG_RESET;
		end else if (wr_ok && (reg_addr_in == ADDR_PROG_CTRL)
			&& reg_wdata_in[PROG_START_BIT]) begin
			key_r <= REG_RESET; // RULE20
		end else if (wr_ok && (reg_addr_in == ADDR_UNLOCK_KEY)) begin
			key_r <= reg_wdata_in; // RULE8
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			latch_en_r <= 1'b0;
		end else if (wr_ok && (reg_addr_in == ADDR_PROG_CTRL)) begin
			latch_en_r <= reg_wdata_in[LATCH_EN_BIT]; // RULE7
		end
	end

	// Start is set only by an accepted request; done clears it
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prog_start_r <= 1'b0;
		end else if (burn_start) begin
			prog_start_r <= 1'b1;
		end else if (burn_done) begin
			prog_start_r <= 1'b0; // RULE11
		end
	end

	// Image is frozen at start so writes during the burn cannot tear it
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			nvm_wdata_out <= '0;
			nvm_burn_out <= 1'b0;
		end else begin
			if (burn_start) begin
				nvm_wdata_out <= {power_cfg_r, bemf_low_r, res_bemf_high_r, res_low_r}; // RULE9
			end
			nvm_burn_out <= burn_start || (burn_busy && !burn_done);
		end
	end

	burn_timer #(
		.CYCLES(BURN_CYCLE_COUNT)
	) u_burn_timer (
		.mclk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.start_in(burn_start),
		.busy_out(burn_busy), // RULE10
		.done_out(burn_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Power state

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PWR_RUN: begin
				if (power_cfg_r[SLEEP_SEL_BIT] && pin_zero_r) begin
					state_nxt = PWR_SLEEP; // RULE2
				end else if (!power_cfg_r[SLEEP_SEL_BIT] && (pin_zero_r || cmd_zero)) begin
					state_nxt = PWR_STANDBY; // RULE1
				end
			end
			PWR_STANDBY: begin
				if (power_cfg_r[SLEEP_SEL_BIT] && pin_zero_r) begin
					state_nxt = PWR_SLEEP;
				end else if (!pin_zero_r && !cmd_zero) begin
					state_nxt = PWR_RUN; // RULE4
				end
			end
			PWR_SLEEP: begin
				if (!pin_zero_r) begin
					state_nxt = PWR_RUN; // RULE3
				end
			end
			default: begin
				state_nxt = PWR_STANDBY;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= PWR_STANDBY;
		end else if (!load_pending_r) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			serial_enable_out <= 1'b1;
			motor_drive_enable_out <= 1'b0;
		end else begin
			serial_enable_out <= (state_nxt != PWR_SLEEP); // RULE3 RULE4
			// No drive before the fuse image has landed after a wake
			motor_drive_enable_out <= (state_nxt == PWR_RUN) && !load_pending_r
				&& !sleep_exit; // RULE5 RULE6
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output duty

	logic [7:0] pwm_cnt_r;
	logic [7:0] duty;

	// Duty follows the speed MSB; all ones is held high for full amplitude
	assign duty = speed_msb_r;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pwm_cnt_r <= 8'h00;
			pwm_out <= 1'b0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 8'h01;
			pwm_out <= motor_drive_enable_out
				&& ((duty == DUTY_FULL) || (pwm_cnt_r < duty)); // RULE17 RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Motor codes and read-back

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_resistance_code_out <= 12'h000;
			bemf_constant_code_out <= 12'h000;
		end else begin
			// One count is RES_LSB_MOHM, up to 40.95 ohm
			phase_resistance_code_out <= {res_bemf_high_r[3:0], res_low_r}; // RULE13 RULE14
			// One count is BEMF_LSB_MV_PER_HZ, up to 4095
			bemf_constant_code_out <= {res_bemf_high_r[7:4], bemf_low_r}; // RULE15 RULE16
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in && (state_r != PWR_SLEEP)) begin
			case (reg_addr_in)
				ADDR_SPEED_MSB: begin
					reg_rdata_out <= speed_msb_r;
				end
				ADDR_SPEED_LSB: begin
					reg_rdata_out <= speed_lsb_r;
				end
				ADDR_UNLOCK_KEY: begin
					reg_rdata_out <= key_r;
				end
				ADDR_PROG_CTRL: begin
					reg_rdata_out <= {5'h00, latch_en_r, 1'b0, prog_start_r}; // RULE11
				end
				ADDR_POWER_STATUS: begin
					reg_rdata_out <= {5'h00, burn_busy, state_r == PWR_SLEEP,
						state_r == PWR_STANDBY};
				end
				ADDR_RES_LOW: begin
					reg_rdata_out <= res_low_r;
				end
				ADDR_RES_BEMF_HIGH: begin
					reg_rdata_out <= res_bemf_high_r;
				end
				ADDR_BEMF_LOW: begin
					reg_rdata_out <= bemf_low_r;
				end
				ADDR_POWER_CFG: begin
					reg_rdata_out <= power_cfg_r;
				end
				default: begin
					reg_rdata_out <= 8'h00;
				end
			endcase
		end
	end
endmodule : nvm_power_ctrl

// ==== nvm_power_ctrl_chk.sv ====
/* Port checker for nvm_power_ctrl.
   Assumes a bind with the same burn count and one clock domain. */
`timescale 1ns/1ps
module nvm_power_ctrl_chk
	import nvm_cfg_pkg::*;
#(
	parameter int BURN_CYCLE_COUNT = 20
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic speed_pin_zero_in,
	input wire logic [nvm_cfg_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [nvm_cfg_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [nvm_cfg_pkg::IMG_W-1:0] nvm_rdata_in,
	input wire logic [nvm_cfg_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic serial_enable_out,
	input wire logic motor_drive_enable_out,
	input wire logic pwm_out,
	input wire logic [11:0] phase_resistance_code_out,
	input wire logic [11:0] bemf_constant_code_out,
	input wire logic [nvm_cfg_pkg::IMG_W-1:0] nvm_wdata_out,
	input wire logic nvm_burn_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	int burn_cnt_r;
	////////////////////////////////////////////////////////////////////////////////
	// Length of the burn, counted while it stands
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			burn_cnt_r <= 0;
		end else if (nvm_burn_out) begin
			burn_cnt_r <= burn_cnt_r + 1;
		end else begin
			burn_cnt_r <= 0;
		end
	end
	burn_len_a: assert property ($fell(nvm_burn_out) |-> burn_cnt_r == BURN_CYCLE_COUNT)
		else $error("burn length wrong");
	burn_cause_a: assert property ($rose(nvm_burn_out) |-> $past(reg_wr_in &&
		reg_addr_in == ADDR_PROG_CTRL && reg_wdata_in[0] && reg_wdata_in[2]))
		else $error("burn without start request");
	burn_image_a: assert property (nvm_burn_out && $past(nvm_burn_out) |-> $stable(nvm_wdata_out))
		else $error("burn image moved");
	key_cleared_a: assert property (reg_rd_in && serial_enable_out && nvm_burn_out &&
		reg_addr_in == ADDR_UNLOCK_KEY |=> reg_rdata_out == 8'h00)
		else $error("key not cleared");
	sleep_drive_a: assert property (!serial_enable_out |-> !motor_drive_enable_out)
		else $error("drive on in sleep");
	pwm_quiet_a: assert property (!motor_drive_enable_out[*2] |-> !pwm_out)
		else $error("pwm while stopped");
	pin_stop_a: assert property (speed_pin_zero_in[*5] |=> !motor_drive_enable_out)
		else $error("drive on at zero pin");
	sleep_hold_a: assert property (!serial_enable_out && speed_pin_zero_in &&
		$past(speed_pin_zero_in) && $past(speed_pin_zero_in, 2) |=> !serial_enable_out)
		else $error("left sleep without pin");
	sleep_read_a: assert property (!serial_enable_out |=> $stable(reg_rdata_out))
		else $error("read served in sleep");
endmodule : nvm_power_ctrl_chk

// ==== nvm_power_ctrl_tb.sv ====
/* Self-checking bench for nvm_power_ctrl with a host model and a fixed fuse image.
   Assumes a short burn count so programming ends within the run. */
`timescale 1ns/1ps
module nvm_power_ctrl_tb;
	import nvm_cfg_pkg::*;
	localparam int BURN_N = 20;
	localparam logic [31:0] IMG = 32'h0034A512;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic pin_zero = 1'b1;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd, ser_en, drv_en, pwm, burn;
	logic [11:0] res_code, bemf_code;
	logic [31:0] wimg;
	int err_count = 0;
	int checked = 0;
	host_model h (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
		.reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
	nvm_power_ctrl #(.BURN_CYCLE_COUNT(BURN_N)) uut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.speed_pin_zero_in(pin_zero), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .nvm_rdata_in(IMG), .reg_rdata_out(rdata),
		.serial_enable_out(ser_en), .motor_drive_enable_out(drv_en), .pwm_out(pwm),
		.phase_resistance_code_out(res_code), .bemf_constant_code_out(bemf_code),
		.nvm_wdata_out(wimg), .nvm_burn_out(burn));
	initial begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : chk
	task automatic settle;
		repeat (8) @(posedge mclk_in);
		#1;
	endtask : settle
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_codes;
		chk(res_code, 12'h512, "loaded resistance");
		chk(bemf_code, 12'hA34, "loaded bemf");
		h.wr(ADDR_RES_LOW, 8'hFF);
		h.wr(ADDR_RES_BEMF_HIGH, 8'h30);
		h.wr(ADDR_BEMF_LOW, 8'hFF);
		settle();
		chk(res_code, 12'h0FF, "resistance split");
		chk(bemf_code, 12'h3FF, "bemf split");
		h.wr(ADDR_RES_BEMF_HIGH, 8'hFF);
		settle();
		chk(res_code, 12'hFFF, "resistance full scale");
		chk(bemf_code, 12'd4095, "bemf full scale");
		h.rd(ADDR_RES_BEMF_HIGH, d);
		chk(d, 8'hFF, "override readback");
		h.rd(8'h55, d);
		chk(d, 8'h00, "unmapped read");
		$display("test codes done");
	endtask : t_codes
	task automatic t_run;
		int hi;
		hi = 0;
		pin_zero = 1'b0;
		h.wr(ADDR_SPEED_MSB, 8'h80);
		h.wr(ADDR_SPEED_LSB, 8'h01);
		settle();
		chk(drv_en, 1'b1, "run on speed");
		repeat (256) begin
			@(posedge mclk_in);
			#1;
			if (pwm === 1'b1) hi++;
		end
		chk(32'(hi >= 127 && hi <= 129), 1, "half duty");
		pin_zero = 1'b1;
		settle();
		chk(drv_en, 1'b0, "pin zero stops");
		chk(ser_en, 1'b1, "serial on in standby");
		pin_zero = 1'b0;
		settle();
		chk(drv_en, 1'b1, "run again");
		h.wr(ADDR_SPEED_MSB, 8'h00);
		h.wr(ADDR_SPEED_LSB, 8'h00);
		settle();
		chk(drv_en, 1'b0, "serial zero stops");
		h.rd(ADDR_SPEED_LSB, d);
		chk(d, 8'h00, "speed low byte");
		$display("test run done");
	endtask : t_run
	task automatic t_prog;
		int n;
		h.wr(ADDR_PROG_CTRL, 8'h05);
		settle();
		chk(burn, 1'b0, "start without key");
		h.prog(8'h12, 8'h45, 8'h67);
		chk(burn, 1'b1, "burn started");
		chk(wimg, 32'h00674512, "burn image");
		h.rd(ADDR_PROG_CTRL, d);
		chk(d[0], 1'b1, "start bit busy");
		h.rd(ADDR_UNLOCK_KEY, d);
		chk(d, 8'h00, "key cleared");
		n = 0;
		while (burn === 1'b1 && n < 4 * BURN_N) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		chk(burn, 1'b0, "burn ended");
		// Burn starts at the start write edge; four edges pass in the two reads
		chk(n, BURN_N - 4, "burn length");
		h.rd(ADDR_PROG_CTRL, d);
		chk(d[0], 1'b0, "start bit cleared");
		$display("test prog done");
	endtask : t_prog
	task automatic t_sleep;
		h.wr(ADDR_POWER_CFG, 8'h04);
		h.wr(ADDR_RES_LOW, 8'h77);
		pin_zero = 1'b1;
		settle();
		chk(ser_en, 1'b0, "serial off in sleep");
		chk(drv_en, 1'b0, "drive off in sleep");
		h.wr(ADDR_SPEED_MSB, 8'hFF);
		h.wr(ADDR_SPEED_LSB, 8'hFF);
		settle();
		chk(ser_en, 1'b0, "serial speed cannot wake");
		pin_zero = 1'b0;
		settle();
		chk(ser_en, 1'b1, "pin wakes");
		chk(res_code, 12'h512, "reload on wake");
		h.rd(ADDR_POWER_CFG, d);
		chk(d, 8'h00, "select reloaded");
		$display("test sleep done");
	endtask : t_sleep
	initial begin
		repeat (3) @(posedge mclk_in);
		#1;
		arst_n_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		t_codes();
		t_run();
		t_prog();
		t_sleep();
		conclude();
	end
	// Whole run is a few hundred cycles
	initial begin
		#50000;
		err_count++;
		conclude();
	end
endmodule : nvm_power_ctrl_tb

bind nvm_power_ctrl nvm_power_ctrl_chk #(.BURN_CYCLE_COUNT(BURN_CYCLE_COUNT)) chk_i (
	.mclk_in(mclk_in), .arst_n_in(arst_n_in), .speed_pin_zero_in(speed_pin_zero_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .nvm_rdata_in(nvm_rdata_in), .reg_rdata_out(reg_rdata_out),
	.serial_enable_out(serial_enable_out), .motor_drive_enable_out(motor_drive_enable_out),
	.pwm_out(pwm_out), .phase_resistance_code_out(phase_resistance_code_out),
	.bemf_constant_code_out(bemf_constant_code_out), .nvm_wdata_out(nvm_wdata_out),
	.nvm_burn_out(nvm_burn_out));
